// *** src/uhgc_top.sv ***
/*
 * Host global control and interrupt block: control register, status
 * flags with clear/force, enable mask with set/clear, one interrupt.
 * Assumes the bus-signalling engine below it reports completion of
 * reset, resume and frame markers as one-cycle pulses, and that pipe and
 * DMA summary inputs are levels from their own status logic.
 */
module uhgc_top
  import uhgc_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] pipe_irq_flag_i,
  input wire logic [7:1] dma_chan_irq_flag_i,
  input wire logic frame_marker_sent_i,
  input wire logic upstream_resume_i,
  input wire logic resume_done_i,
  input wire logic reset_done_i,
  input wire logic detach_i,
  input wire logic attach_i,
  input wire logic bus_power_request_i,
  input wire logic clock_freeze_i,
  output logic frame_marker_gen_en_o,
  output logic bus_reset_drive_o,
  output logic bus_resume_drive_o,
  output logic high_speed_allowed_o,
  output logic irq_o
);

  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic [31:0] wdat;
  logic ctrl_wr;
  logic frame_en_q;
  logic reset_q;
  logic resume_q;
  uhgc_speed_t speed_q;
  logic [31:0] stat_q;
  logic [31:0] stat_d;
  logic [31:0] en_q;
  logic [31:0] stat_view;
  logic [31:0] evt_set;
  logic [31:0] clr_mask;
  logic [31:0] force_mask;
  logic [6:0] dma_src_q;
  logic [31:0] dma_drop;
  logic [31:0] rd_d;
  logic wake_evt;

  // Zero wait state slave: the access phase always completes at once
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  assign wdat = pwdata_i;
  assign ctrl_wr = wr_acc && (paddr_i == UHGC_OFS_CTRL);

  always_comb begin
    unique case (paddr_i)
      UHGC_OFS_CTRL, UHGC_OFS_STAT, UHGC_OFS_CLR, UHGC_OFS_FORCE,
      UHGC_OFS_EN, UHGC_OFS_ENCLR, UHGC_OFS_ENSET: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Frame-marker enable; hardware set wins over a software zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_en_q <= 1'b0;
    end else if ((ctrl_wr && wdat[UHGC_CTL_RESET]) || upstream_resume_i) begin
      frame_en_q <= 1'b1;
    end else if (ctrl_wr) begin
      frame_en_q <= wdat[UHGC_CTL_FRAME_EN];
    end
  end

  // Bus reset request
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reset_q <= 1'b0;
    end else if (ctrl_wr && wdat[UHGC_CTL_RESET]) begin
      reset_q <= 1'b1;
    end else if (reset_done_i) begin
      reset_q <= 1'b0;
    end else if (ctrl_wr) begin
      // Software may abort a reset, typically after a detach
      reset_q <= 1'b0;
    end
  end

  // Resume request; a reset request cancels it
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resume_q <= 1'b0;
    end else if (ctrl_wr && wdat[UHGC_CTL_RESET]) begin
      resume_q <= 1'b0;
    end else if (ctrl_wr && wdat[UHGC_CTL_RESUME]) begin
      resume_q <= 1'b1;
    end else if (resume_done_i || reset_q) begin
      resume_q <= 1'b0;
    end
  end

  // Reserved codes are stored as written; only 00 allows high speed
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      speed_q <= UHGC_SPD_NORMAL;
    end else if (ctrl_wr) begin
      speed_q <= uhgc_speed_t'(wdat[UHGC_CTL_SPD_HI:UHGC_CTL_SPD_LO]);
    end
  end

  // Wake-up: the clock freeze input gates nothing in this block, so this
  // flag path ignores the freeze and wake-up still reaches software
  assign wake_evt = (!frame_en_q && (upstream_resume_i || detach_i))
                  || !bus_power_request_i;

  always_comb begin
    evt_set = UHGC_ZERO;
    evt_set[UHGC_ST_ATTACH] = attach_i;
    evt_set[UHGC_ST_DETACH] = detach_i;
    evt_set[UHGC_ST_RSTSENT] = reset_done_i && reset_q;
    evt_set[UHGC_ST_RSMDONE] = resume_done_i && resume_q;
    evt_set[UHGC_ST_UPRSM] = upstream_resume_i;
    evt_set[UHGC_ST_FRAME] = frame_marker_sent_i && frame_en_q;
    evt_set[UHGC_ST_WAKE] = wake_evt;
  end

  assign clr_mask = (wr_acc && paddr_i == UHGC_OFS_CLR) ?
                    (wdat & UHGC_EVT_MASK) : UHGC_ZERO;
  assign force_mask = (wr_acc && paddr_i == UHGC_OFS_FORCE) ?
                      (wdat & UHGC_FORCE_MASK) : UHGC_ZERO;

  // Sticky event and forced bits; set beats clear in the same cycle.
  // Direct writes to the status offset have no path here.
  assign stat_d = ((stat_q & ~clr_mask & ~dma_drop) | evt_set | force_mask)
                & UHGC_FORCE_MASK;

  // Channel source levels of the previous cycle, to see a source fall
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dma_src_q <= '0;
    end else begin
      dma_src_q <= dma_chan_irq_flag_i;
    end
  end

  // A forced DMA bit is released when its channel source is cleared
  always_comb begin
    dma_drop = UHGC_ZERO;
    dma_drop[UHGC_ST_DMA_HI:UHGC_ST_DMA_LO] =
      dma_src_q & ~dma_chan_irq_flag_i;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_q <= UHGC_RST_STAT;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Pipe bits are pure mirrors; DMA bits follow the source unless forced
  always_comb begin
    stat_view = stat_q;
    stat_view[UHGC_ST_PIPE_HI:UHGC_ST_PIPE_LO] = pipe_irq_flag_i;
    // A forced DMA bit drops once the channel source is low again
    stat_view[UHGC_ST_DMA_HI:UHGC_ST_DMA_LO] =
      dma_chan_irq_flag_i | stat_q[UHGC_ST_DMA_HI:UHGC_ST_DMA_LO];
  end

  // A forced DMA bit with a source that never rises stays set: the clear
  // register has no DMA bits, so only the channel itself can release it.

  // Enable mask
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q <= UHGC_RST_EN;
    end else if (wr_acc && paddr_i == UHGC_OFS_ENSET) begin
      en_q <= en_q | (wdat & UHGC_EN_MASK);
    end else if (wr_acc && paddr_i == UHGC_OFS_ENCLR) begin
      en_q <= en_q & ~wdat;
    end
  end

  always_comb begin
    rd_d = UHGC_ZERO;
    unique case (paddr_i)
      UHGC_OFS_CTRL: begin
        rd_d[UHGC_CTL_FRAME_EN] = frame_en_q;
        rd_d[UHGC_CTL_RESET] = reset_q;
        rd_d[UHGC_CTL_RESUME] = resume_q;
        rd_d[UHGC_CTL_SPD_HI:UHGC_CTL_SPD_LO] = speed_q;
      end
      UHGC_OFS_STAT: rd_d = stat_view;
      UHGC_OFS_EN: rd_d = en_q;
      default: rd_d = UHGC_ZERO;
    endcase
  end

  // Registered read data: captured in setup so it is valid in access
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= UHGC_ZERO;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_d;
    end
  end

  // Ready and error in the access cycle, one cycle after setup
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !hit;
    end
  end

  // Bus-facing drives
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_marker_gen_en_o <= 1'b0;
      bus_reset_drive_o <= 1'b0;
      bus_resume_drive_o <= 1'b0;
      high_speed_allowed_o <= 1'b0;
    end else begin
      frame_marker_gen_en_o <= frame_en_q;
      bus_reset_drive_o <= reset_q;
      bus_resume_drive_o <= resume_q && !reset_q;
      high_speed_allowed_o <= (speed_q == UHGC_SPD_NORMAL);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_view & en_q);
    end
  end

  logic unused_ok;
  assign unused_ok = rd_acc ^ clock_freeze_i;

endmodule : uhgc_top

// *** src/uhgc_pkg.sv ***
/*
 * Package for the host global control and interrupt block: register
 * offsets, field positions, masks and the speed policy encoding.
 * Assumes a 32-bit APB with word-aligned byte addresses.
 */
package uhgc_pkg;
  localparam int unsigned UHGC_AW = 12;
  localparam logic [11:0] UHGC_OFS_CTRL = 12'h400;
  localparam logic [11:0] UHGC_OFS_STAT = 12'h404;
  localparam logic [11:0] UHGC_OFS_CLR = 12'h408;
  localparam logic [11:0] UHGC_OFS_FORCE = 12'h40C;
  localparam logic [11:0] UHGC_OFS_EN = 12'h410;
  localparam logic [11:0] UHGC_OFS_ENCLR = 12'h414;
  localparam logic [11:0] UHGC_OFS_ENSET = 12'h418;

  // Control register fields
  localparam int unsigned UHGC_CTL_FRAME_EN = 8;
  localparam int unsigned UHGC_CTL_RESET = 9;
  localparam int unsigned UHGC_CTL_RESUME = 10;
  localparam int unsigned UHGC_CTL_SPD_LO = 12;
  localparam int unsigned UHGC_CTL_SPD_HI = 13;

  // Status fields
  localparam int unsigned UHGC_ST_ATTACH = 0;
  localparam int unsigned UHGC_ST_DETACH = 1;
  localparam int unsigned UHGC_ST_RSTSENT = 2;
  localparam int unsigned UHGC_ST_RSMDONE = 3;
  localparam int unsigned UHGC_ST_UPRSM = 4;
  localparam int unsigned UHGC_ST_FRAME = 5;
  localparam int unsigned UHGC_ST_WAKE = 6;
  localparam int unsigned UHGC_ST_PIPE_LO = 8;
  localparam int unsigned UHGC_ST_PIPE_HI = 15;
  localparam int unsigned UHGC_ST_DMA_LO = 25;
  localparam int unsigned UHGC_ST_DMA_HI = 31;

  localparam logic [31:0] UHGC_EVT_MASK = 32'h0000007F;
  localparam logic [31:0] UHGC_FORCE_MASK = 32'hFE00007F;
  localparam logic [31:0] UHGC_EN_MASK = 32'hFE00FF7F;
  localparam logic [31:0] UHGC_CTRL_MASK = 32'h00003700;
  localparam logic [31:0] UHGC_ZERO = 32'h00000000;
  localparam logic [31:0] UHGC_RST_STAT = 32'h00000000;
  localparam logic [31:0] UHGC_RST_EN = 32'h00000000;

  typedef enum logic [1:0] {
    UHGC_SPD_NORMAL = 2'b00,
    UHGC_SPD_RSVD1 = 2'b01,
    UHGC_SPD_RSVD2 = 2'b10,
    UHGC_SPD_FULL = 2'b11
  } uhgc_speed_t;
endpackage : uhgc_pkg

// *** bench/uhgc_monitor.sv ***
/* Checker for uhgc_top: bus drive levels against control writes and events, and clear register reads.
   Assumes it is bound to uhgc_top and sees only its ports. */
module uhgc_monitor
  import uhgc_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic upstream_resume_i,
  input wire logic reset_done_i,
  input wire logic frame_marker_gen_en_o,
  input wire logic bus_reset_drive_o,
  input wire logic bus_resume_drive_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_acc;
    psel_i && penable_i && pready_o;
  endsequence
  sequence s_ctl;
    s_acc ##0 (pwrite_i && paddr_i == UHGC_OFS_CTRL);
  endsequence
  a_reset_drive: assert property (s_ctl ##0 pwdata_i[9]
    |-> ##[1:2] bus_reset_drive_o) else $error("reset not driven");
  a_reset_frame_on: assert property (s_ctl ##0 pwdata_i[9]
    |-> ##[1:2] frame_marker_gen_en_o) else $error("frame gen not on");
  a_resume_drive: assert property (s_ctl ##0 (pwdata_i[10]
    && !pwdata_i[9]) |-> ##[1:2] bus_resume_drive_o)
    else $error("resume not driven");
  a_resume_zero_write: assert property (s_ctl ##0 (!pwdata_i[10]
    && !bus_resume_drive_o) |=> !bus_resume_drive_o [*2])
    else $error("resume started by zero");
  a_resume_cancel: assert property (s_ctl ##0 pwdata_i[9]
    |-> ##[1:2] !bus_resume_drive_o) else $error("resume not cancelled");
  a_reset_abort: assert property (s_ctl ##0 (!pwdata_i[9]
    && bus_reset_drive_o) |-> ##[1:2] !bus_reset_drive_o)
    else $error("reset not aborted");
  a_reset_self_clear: assert property (reset_done_i
    && bus_reset_drive_o && !psel_i |-> ##[1:2] !bus_reset_drive_o)
    else $error("reset bit not cleared");
  a_upstream_frame_on: assert property (upstream_resume_i
    |-> ##[1:3] frame_marker_gen_en_o) else $error("frame gen not on");
  a_clear_reads_zero: assert property (s_acc ##0 (!pwrite_i
    && paddr_i == UHGC_OFS_CLR) |-> prdata_o == UHGC_ZERO)
    else $error("clear register read not zero");
endmodule : uhgc_monitor
bind uhgc_top uhgc_monitor u_mon (.*);

// *** bench/uhgc_peer.sv ***
/* Peripheral side model: reports reset and resume completion in the LAT-th
   cycles of drive, and frame markers every 8 cycles while enabled.
   Assumes registered drive levels from uhgc_top. */
module uhgc_peer #(
  parameter int LAT = 12
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic rst_drv_i,
  input wire logic rsm_drv_i,
  input wire logic frm_en_i,
  output logic reset_done_o,
  output logic resume_done_o,
  output logic frame_marker_sent_o
);
  int rc;
  int sc;
  logic [2:0] fc;
  // Reset and resume counters park at LAT so a held drive gives one done pulse only
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rc <= 0;
      sc <= 0;
      fc <= 3'h0;
    end else begin
      rc <= !rst_drv_i ? 0 : (rc < LAT ? rc + 1 : rc);
      sc <= !rsm_drv_i ? 0 : (sc < LAT ? sc + 1 : sc);
      fc <= frm_en_i ? fc + 3'h1 : 3'h0;
    end
  end
  assign reset_done_o = rst_drv_i && rc == LAT - 1;
  assign resume_done_o = rsm_drv_i && sc == LAT - 1;
  assign frame_marker_sent_o = frm_en_i && fc == 3'h7;
endmodule : uhgc_peer

// *** bench/uhgc_top_tb.sv ***
/* Self-checking bench for uhgc_top over APB with a peripheral model.
   Assumes the hand-over timing: one-cycle pready, registered outputs. */
module uhgc_top_tb
  import uhgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'h0, nrst_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
  logic pwrite_i = 1'h0, se, attach_i = 1'h0, detach_i = 1'h0;
  logic upstream_resume_i = 1'h0, bus_power_request_i = 1'h0;
  logic clock_freeze_i = 1'h0, pready_o, pslverr_o, frame_marker_sent_i;
  logic resume_done_i, reset_done_i, frame_marker_gen_en_o, irq_o;
  logic bus_reset_drive_o, bus_resume_drive_o, high_speed_allowed_o;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, r;
  logic [7:0] pipe_irq_flag_i = '0;
  logic [7:1] dma_chan_irq_flag_i = '0;
  int num_errors = 0, total_checks = 0, n;
  always #10 clock_i = ~clock_i;
  uhgc_top uut (.*);
  uhgc_peer peer (.clock_i(clock_i), .nrst_i(nrst_i),
    .rst_drv_i(bus_reset_drive_o), .rsm_drv_i(bus_resume_drive_o),
    .frm_en_i(frame_marker_gen_en_o), .reset_done_o(reset_done_i),
    .resume_done_o(resume_done_i), .frame_marker_sent_o(frame_marker_sent_i));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic tmo;
    if (n >= 60) begin
      num_errors++;
      $display("[ERR] %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask : tmo
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'h1;
    for (n = 0; n < 60; n++) begin
      @(posedge clock_i);
      if (pready_o === 1'h1) break;
    end
    tmo();
    r = prdata_o;
    se = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, UHGC_ZERO);
    chk(r, e);
  endtask : rd
  task automatic pulse(input logic [2:0] k);
    @(posedge clock_i);
    {attach_i, detach_i, upstream_resume_i} <= k;
    @(posedge clock_i);
    {attach_i, detach_i, upstream_resume_i} <= 3'h0;
  endtask : pulse
  // Two edges first: the drive level shows one cycle after the commit
  task automatic wdrv(input logic rs);
    repeat (2) @(posedge clock_i);
    for (n = 0; n < 60; n++) begin
      @(posedge clock_i);
      if ((rs ? bus_reset_drive_o : bus_resume_drive_o) === 1'h0) break;
    end
    tmo();
  endtask : wdrv
  task automatic t_regs;
    rd(UHGC_OFS_STAT, 32'h00000040);
    bus_power_request_i <= 1'h1;
    wr(UHGC_OFS_CLR, 32'h00000040);
    rd(UHGC_OFS_STAT, UHGC_RST_STAT);
    rd(UHGC_OFS_EN, UHGC_RST_EN);
    rd(UHGC_OFS_CLR, UHGC_ZERO);
    rd(UHGC_OFS_FORCE, UHGC_ZERO);
    rd(12'h7FC, UHGC_ZERO);
    chk({31'h0, se}, 32'h1);
  endtask : t_regs
  task automatic t_en;
    wr(UHGC_OFS_EN, 32'hFFFFFFFF);
    wr(UHGC_OFS_STAT, 32'hFFFFFFFF);
    rd(UHGC_OFS_EN, UHGC_ZERO);
    rd(UHGC_OFS_STAT, UHGC_ZERO);
    wr(UHGC_OFS_ENSET, 32'hFFFFFFFF);
    wr(UHGC_OFS_ENCLR, 32'h0000FF01);
    rd(UHGC_OFS_EN, UHGC_EN_MASK & ~32'h0000FF01);
  endtask : t_en
  task automatic t_force;
    wr(UHGC_OFS_FORCE, 32'h0000003F);
    rd(UHGC_OFS_STAT, 32'h0000003F);
    chk({31'h0, irq_o}, 32'h1);
    wr(UHGC_OFS_CLR, 32'h0000003E);
    rd(UHGC_OFS_STAT, 32'h00000001);
    chk({31'h0, irq_o}, 32'h0);
    wr(UHGC_OFS_CLR, 32'h00000001);
  endtask : t_force
  task automatic t_mirror;
    wr(UHGC_OFS_FORCE, 32'h02000000);
    rd(UHGC_OFS_STAT, 32'h02000000);
    pipe_irq_flag_i <= 8'hA5;
    dma_chan_irq_flag_i <= 7'h55;
    rd(UHGC_OFS_STAT, 32'hAA00A500);
    chk({31'h0, irq_o}, 32'h1);
    dma_chan_irq_flag_i <= 7'h00;
    rd(UHGC_OFS_STAT, 32'h0000A500);
    chk({31'h0, irq_o}, 32'h0);
    pipe_irq_flag_i <= 8'h00;
    rd(UHGC_OFS_STAT, UHGC_ZERO);
  endtask : t_mirror
  task automatic t_events;
    clock_freeze_i <= 1'h1;
    pulse(3'h4);
    pulse(3'h2);
    rd(UHGC_OFS_STAT, 32'h00000043);
    clock_freeze_i <= 1'h0;
    wr(UHGC_OFS_CLR, 32'h00000043);
    rd(UHGC_OFS_STAT, UHGC_ZERO);
    pulse(3'h1);
    xfer(1'h0, UHGC_OFS_STAT, UHGC_ZERO);
    chk(r & 32'h5F, 32'h00000050);
    chk({31'h0, frame_marker_gen_en_o}, 32'h1);
    wr(UHGC_OFS_CLR, 32'h0000007F);
    repeat (10) @(posedge clock_i);
    xfer(1'h0, UHGC_OFS_STAT, UHGC_ZERO);
    chk(r & 32'h20, 32'h00000020);
  endtask : t_events
  task automatic t_bus;
    wr(UHGC_OFS_CTRL, 32'h00000300);
    wdrv(1'h1);
    chk({31'h0, high_speed_allowed_o}, 32'h1);
    xfer(1'h0, UHGC_OFS_STAT, UHGC_ZERO);
    chk(r & 32'h0C, 32'h00000004);
    wr(UHGC_OFS_CTRL, 32'h00000500);
    wdrv(1'h0);
    xfer(1'h0, UHGC_OFS_STAT, UHGC_ZERO);
    chk(r & 32'h0C, 32'h0000000C);
    wr(UHGC_OFS_CLR, 32'h0000007F);
    wr(UHGC_OFS_CTRL, 32'h00000300);
    pulse(3'h2);
    wr(UHGC_OFS_CTRL, 32'h00000100);
    wdrv(1'h1);
    wr(UHGC_OFS_CTRL, 32'h00000500);
    wr(UHGC_OFS_CTRL, 32'h00000300);
    wdrv(1'h1);
    xfer(1'h0, UHGC_OFS_STAT, UHGC_ZERO);
    chk(r & 32'h0C, 32'h00000004);
    wr(UHGC_OFS_CTRL, 32'h00003100);
    xfer(1'h0, UHGC_OFS_CTRL, UHGC_ZERO);
    chk(r & UHGC_CTRL_MASK, 32'h00003100);
    chk({31'h0, high_speed_allowed_o}, 32'h0);
  endtask : t_bus
  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'h1;
    t_regs();
    t_en();
    t_force();
    t_mirror();
    t_events();
    t_bus();
    tally_and_finish();
  end
endmodule : uhgc_top_tb
